// ### verilog/boot_loader_pkg.sv
// Shared constants and types for the serial EEPROM boot loader.
package boot_loader_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCL_PERIOD_NS = 80;
    localparam int SCL_QUARTER_NS = SCL_PERIOD_NS / 4;
    localparam int SCL_QUARTER_CYCLES_INT =
        (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
        (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SCL_QUARTER_CYCLES = 8'(SCL_QUARTER_CYCLES_INT);

    localparam logic [7:0] EEPROM_DEV_WRITE = 8'ha0;
    localparam logic [7:0] EEPROM_DEV_READ = 8'ha1;
    localparam logic [7:0] EEPROM_START_LOC = 8'h00;

    localparam logic [13:0] LINE_BASE_FIRST = 14'h0017;
    localparam logic [13:0] LINE_BASE_LAST = 14'h001a;
    localparam logic [13:0] LINE_COPY_FIRST = 14'h002b;
    localparam logic [13:0] LINE_COPY_LAST = 14'h002e;
    localparam logic [13:0] LINE_BOOT_FIRST = 14'h002f;

    localparam logic [31:0] BASE_RESET = 32'h0000_0000;
    localparam logic [31:0] WORD_BYTES = 32'h0000_0004;

    typedef enum logic [3:0] {
        CMD_START = 4'b0001,
        CMD_WRITE = 4'b0010,
        CMD_READ = 4'b0100,
        CMD_STOP = 4'b1000
    } i2c_cmd_e;
endpackage

// ### verilog/i2c_cmd_if.sv
// Command and answer signals between the loader sequencer and the serial bit engine.
interface i2c_cmd_if;
    logic cmd_valid;
    boot_loader_pkg::i2c_cmd_e cmd;
    logic [7:0] tx_byte;
    logic ack_bit;
    logic done;
    logic [7:0] rx_byte;
    logic nack;

    modport loader (output cmd_valid, output cmd, output tx_byte, output ack_bit,
                    input done, input rx_byte, input nack);
    modport engine (input cmd_valid, input cmd, input tx_byte, input ack_bit,
                    output done, output rx_byte, output nack);
endinterface

// ### verilog/i2c_byte_engine.sv
// Serial bus bit engine: start, stop, byte write and byte read with chosen acknowledge.
module i2c_byte_engine (
    input wire logic clk_sys,
    input wire logic reset,
    i2c_cmd_if.engine cmd_port,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n
);
    typedef enum logic [3:0] {
        E_IDLE = 4'b0001,
        E_START = 4'b0010,
        E_BITS = 4'b0100,
        E_STOP = 4'b1000
    } eng_state_e;

    eng_state_e state;
    logic [7:0] qcnt;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic [7:0] shift;
    logic is_read;
    logic ack_drive;
    logic sampled;
    logic scl_low;
    logic sda_low;
    logic done;
    logic nack;
    logic bus_held;
    logic scl_meta, scl_sync, sda_meta, sda_sync;

    wire stretch = (phase == 2'd1) && !scl_sync && (state != E_IDLE);
    wire quarter_end = (qcnt == boot_loader_pkg::SCL_QUARTER_CYCLES - 8'h01) && !stretch;
    wire cmd_end = quarter_end && (phase == 2'd3) && (state != E_BITS || bitn == 4'h8);
    wire data_bit_low = is_read ? 1'b0 : !shift[7];
    wire ack_bit_low = is_read ? ack_drive : 1'b0;
    wire bits_sda_low = (bitn == 4'h8) ? ack_bit_low : data_bit_low;
    wire next_scl_low = (state == E_BITS || state == E_START) ? (phase == 2'd0 || phase == 2'd3)
                      : (state == E_STOP) ? (phase == 2'd0) : bus_held;
    wire next_sda_low = (state == E_BITS) ? bits_sda_low
                      : (state == E_START) ? (phase >= 2'd2)
                      : (state == E_STOP) ? (phase != 2'd3) : 1'b0;

    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n = !scl_low;
    assign sda_oe_n = !sda_low;
    assign cmd_port.done = done;
    assign cmd_port.rx_byte = shift;
    assign cmd_port.nack = nack;

    always_ff @(posedge clk_sys) begin
        scl_meta <= scl_in;
        scl_sync <= scl_meta;
        sda_meta <= sda_in;
        sda_sync <= sda_meta;
        scl_low <= reset ? 1'b0 : next_scl_low;
        sda_low <= reset ? 1'b0 : next_sda_low;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= E_IDLE;
            qcnt <= 8'h00;
            phase <= 2'd0;
            bitn <= 4'h0;
            shift <= 8'h00;
            is_read <= 1'b0;
            ack_drive <= 1'b0;
            sampled <= 1'b0;
            done <= 1'b0;
            nack <= 1'b0;
            bus_held <= 1'b0;
        end else begin
            done <= cmd_end;
            if (state == E_IDLE) begin
                qcnt <= 8'h00;
                phase <= 2'd0;
                bitn <= 4'h0;
                if (cmd_port.cmd_valid) begin
                    unique case (cmd_port.cmd)
                        boot_loader_pkg::CMD_START: state <= E_START;
                        boot_loader_pkg::CMD_STOP: state <= E_STOP;
                        default: state <= E_BITS;
                    endcase
                    is_read <= cmd_port.cmd == boot_loader_pkg::CMD_READ;
                    shift <= cmd_port.tx_byte;
                    ack_drive <= cmd_port.ack_bit;
                end
            end else if (stretch) begin
                qcnt <= 8'h00;
            end else if (!quarter_end) begin
                qcnt <= qcnt + 8'h01;
            end else begin
                qcnt <= 8'h00;
                phase <= phase + 2'd1;
                if (phase == 2'd2) begin
                    sampled <= sda_sync;
                end
                if (phase == 2'd3 && state == E_BITS && bitn != 4'h8) begin
                    shift <= {shift[6:0], sampled};
                end
                if (phase == 2'd3 && state == E_BITS && bitn == 4'h8) begin
                    nack <= sampled;
                end
                if (phase == 2'd3) begin
                    bitn <= bitn + 4'h1;
                end
                if (cmd_end) begin
                    state <= E_IDLE;
                    // Between commands the clock stays low, except after a stop, so that no stray edge reaches the bus.
                    bus_held <= state != E_STOP;
                end
            end
        end
    end
endmodule

// ### verilog/serial_eeprom_boot_loader.sv
// Autonomous boot loader that copies the EEPROM bootstrap image into SDRAM.
// Contract
// - Lines 43 to 46 are read as a second copy of the window base, high byte first.
// - Line 47 is bootstrap byte 0 and lands at window base plus 3.
// - Each group of four bootstrap bytes forms one word with the first byte at its top address.
// - After each received byte the master acknowledges to continue or not to end the read.
// - A dummy write loads the EEPROM address latch before the current-address read.
// - One random read at location 0 of device 1010000 is extended until all bytes are read.
// - Lines 23 to 26 give the window base, high byte first, used for all placement.
module serial_eeprom_boot_loader (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [10:0] boot_word_count,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    output logic mem_wr_valid,
    input wire logic mem_wr_ready,
    output logic [31:0] mem_wr_addr,
    output logic [31:0] mem_wr_data,
    output logic [31:0] sdram_window_base,
    output logic base_copy_match,
    output logic boot_busy,
    output logic boot_done,
    output logic boot_error
);
    typedef enum logic [8:0] {
        S_START = 9'b000000001,
        S_DEV_W = 9'b000000010,
        S_ADDR = 9'b000000100,
        S_RESTART = 9'b000001000,
        S_DEV_R = 9'b000010000,
        S_READ = 9'b000100000,
        S_STOP = 9'b001000000,
        S_DONE = 9'b010000000,
        S_FAIL = 9'b100000000
    } load_state_e;

    load_state_e state;
    logic pending;
    logic failed;
    logic latch_loaded;
    logic [10:0] words;
    logic [13:0] line;
    logic [31:0] base_copy;
    logic [31:0] word_acc;
    logic [10:0] wr_count;

    i2c_cmd_if cmd_bus ();

    i2c_byte_engine engine (
        .clk_sys(clk_sys),
        .reset(reset),
        .cmd_port(cmd_bus.engine),
        .scl_in(scl_in),
        .scl_out(scl_out),
        .scl_oe_n(scl_oe_n),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_n(sda_oe_n)
    );

    wire [13:0] copy_last_line = boot_loader_pkg::LINE_COPY_LAST;
    wire [13:0] last_line = (words == 11'h000) ? copy_last_line
                          : boot_loader_pkg::LINE_BOOT_FIRST + {1'b0, words, 2'b00} - 14'h0001;
    wire is_last = line == last_line;
    wire in_boot = line >= boot_loader_pkg::LINE_BOOT_FIRST;
    wire [13:0] boot_idx = line - boot_loader_pkg::LINE_BOOT_FIRST;
    wire group_end = in_boot && (boot_idx[1:0] == 2'b11);
    wire in_base = line >= boot_loader_pkg::LINE_BASE_FIRST
                 && line <= boot_loader_pkg::LINE_BASE_LAST;
    wire in_copy = line >= boot_loader_pkg::LINE_COPY_FIRST
                 && line <= boot_loader_pkg::LINE_COPY_LAST;
    wire mem_stall = mem_wr_valid && !mem_wr_ready;
    wire issue_ok = !pending && !(state == S_READ && mem_stall)
                  && state != S_DONE && state != S_FAIL;
    wire step = pending && cmd_bus.done;
    wire write_refused = step && (state == S_DEV_W || state == S_ADDR || state == S_DEV_R)
                       && cmd_bus.nack;
    wire rd_done = step && state == S_READ;
    wire [31:0] next_word = {word_acc[23:0], cmd_bus.rx_byte};
    wire [31:0] word_offset = {19'h00000, wr_count, 2'b00};

    assign cmd_bus.cmd_valid = issue_ok;
    assign cmd_bus.cmd = (state == S_START || state == S_RESTART) ? boot_loader_pkg::CMD_START
                       : (state == S_READ) ? boot_loader_pkg::CMD_READ
                       : (state == S_STOP) ? boot_loader_pkg::CMD_STOP
                       : boot_loader_pkg::CMD_WRITE;
    assign cmd_bus.tx_byte = (state == S_DEV_W) ? boot_loader_pkg::EEPROM_DEV_WRITE
                           : (state == S_ADDR) ? boot_loader_pkg::EEPROM_START_LOC
                           : boot_loader_pkg::EEPROM_DEV_READ;
    assign cmd_bus.ack_bit = !is_last;
    assign boot_busy = state != S_DONE && state != S_FAIL;
    assign boot_done = state == S_DONE;
    assign boot_error = state == S_FAIL;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= S_START;
            pending <= 1'b0;
            failed <= 1'b0;
            latch_loaded <= 1'b0;
            words <= 11'h000;
            line <= 14'h0000;
        end else begin
            if (state == S_START && !pending) begin
                words <= boot_word_count;
            end
            if (issue_ok) begin
                pending <= 1'b1;
            end else if (step) begin
                pending <= 1'b0;
            end
            if (step && state == S_ADDR && !cmd_bus.nack) begin
                latch_loaded <= 1'b1;
            end
            if (rd_done) begin
                line <= line + 14'h0001;
            end
            if (write_refused) begin
                failed <= 1'b1;
                state <= S_STOP;
            end else if (step) begin
                unique case (state)
                    S_START: state <= S_DEV_W;
                    S_DEV_W: state <= S_ADDR;
                    S_ADDR: state <= S_RESTART;
                    S_RESTART: state <= S_DEV_R;
                    S_DEV_R: state <= S_READ;
                    S_READ: state <= is_last ? S_STOP : S_READ;
                    S_STOP: state <= failed ? S_FAIL : S_DONE;
                    S_DONE: state <= S_DONE;
                    S_FAIL: state <= S_FAIL;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sdram_window_base <= boot_loader_pkg::BASE_RESET;
            base_copy <= boot_loader_pkg::BASE_RESET;
            base_copy_match <= 1'b0;
            word_acc <= 32'h0000_0000;
        end else if (rd_done) begin
            if (in_base) begin
                sdram_window_base <= {sdram_window_base[23:0], cmd_bus.rx_byte};
            end
            if (in_copy) begin
                base_copy <= {base_copy[23:0], cmd_bus.rx_byte};
            end
            if (line == boot_loader_pkg::LINE_COPY_LAST) begin
                base_copy_match <= {base_copy[23:0], cmd_bus.rx_byte} == sdram_window_base;
            end
            word_acc <= next_word;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mem_wr_valid <= 1'b0;
            mem_wr_addr <= 32'h0000_0000;
            mem_wr_data <= 32'h0000_0000;
            wr_count <= 11'h000;
        end else if (rd_done && group_end) begin
            mem_wr_valid <= 1'b1;
            mem_wr_addr <= sdram_window_base + word_offset;
            mem_wr_data <= next_word;
            wr_count <= wr_count + 11'h001;
        end else if (mem_wr_ready) begin
            mem_wr_valid <= 1'b0;
        end
    end

    logic [7:0] boot_byte0;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            boot_byte0 <= 8'h00;
        end else if (rd_done && line == boot_loader_pkg::LINE_BOOT_FIRST) begin
            boot_byte0 <= cmd_bus.rx_byte;
        end
    end

    logic [10:0] wr_seen;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_seen <= 11'h000;
        end else if (mem_wr_valid && mem_wr_ready) begin
            wr_seen <= wr_seen + 11'h001;
        end
    end

    property p_copy_compare;
        @(posedge clk_sys) disable iff (reset)
        (rd_done && line == boot_loader_pkg::LINE_COPY_LAST)
            |=> base_copy_match == (base_copy == sdram_window_base);
    endproperty
    a_copy_compare: assert property (p_copy_compare) else $error("copy check wrong");

    property p_first_byte_top;
        @(posedge clk_sys) disable iff (reset)
        (mem_wr_valid && wr_seen == 11'h000)
            |-> mem_wr_addr == sdram_window_base && mem_wr_data[31:24] == boot_byte0;
    endproperty
    a_first_byte_top: assert property (p_first_byte_top) else $error("byte 0 misplaced");

    property p_group_word;
        @(posedge clk_sys) disable iff (reset)
        (rd_done && group_end) |=> mem_wr_valid && mem_wr_data[7:0] == $past(cmd_bus.rx_byte)
            && mem_wr_data[15:8] == $past(word_acc[7:0]);
    endproperty
    a_group_word: assert property (p_group_word) else $error("word order wrong");

    property p_last_word;
        @(posedge clk_sys) disable iff (reset)
        (mem_wr_valid && wr_count == words && words != 11'h000 && state != S_READ)
            |-> mem_wr_addr == sdram_window_base + {19'h00000, words, 2'b00}
                - boot_loader_pkg::WORD_BYTES;
    endproperty
    a_last_word: assert property (p_last_word) else $error("last word address wrong");

    property p_ack_choice;
        @(posedge clk_sys) disable iff (reset)
        (cmd_bus.cmd_valid && state == S_READ) |-> cmd_bus.ack_bit == (line != last_line);
    endproperty
    a_ack_choice: assert property (p_ack_choice) else $error("ack choice wrong");

    property p_latch_first;
        @(posedge clk_sys) disable iff (reset)
        (cmd_bus.cmd_valid && state == S_DEV_R) |-> latch_loaded;
    endproperty
    a_latch_first: assert property (p_latch_first) else $error("read before dummy write");

    property p_device_address;
        @(posedge clk_sys) disable iff (reset)
        (cmd_bus.cmd_valid && state == S_DEV_W)
            |-> cmd_bus.tx_byte == 8'ha0 ##1 pending[*2];
    endproperty
    a_device_address: assert property (p_device_address) else $error("bad device byte");

    property p_base_byte;
        @(posedge clk_sys) disable iff (reset)
        (rd_done && line == boot_loader_pkg::LINE_BASE_LAST)
            |=> sdram_window_base[7:0] == $past(cmd_bus.rx_byte)
                && sdram_window_base[15:8] == $past(sdram_window_base[7:0]);
    endproperty
    a_base_byte: assert property (p_base_byte) else $error("base assembly wrong");

    c_boot_done: cover property (@(posedge clk_sys) disable iff (reset) $rose(boot_done));
    c_boot_fail: cover property (@(posedge clk_sys) disable iff (reset) $rose(boot_error));
    c_mem_stall: cover property (@(posedge clk_sys) disable iff (reset)
        mem_wr_valid && !mem_wr_ready);
    c_copy_ok: cover property (@(posedge clk_sys) disable iff (reset) $rose(base_copy_match));
endmodule

// ### testbench/eeprom_model.sv
// Behavioural serial EEPROM that answers the boot loader on the two-wire bus.
module eeprom_model (
    input wire logic scl_w,
    input wire logic sda_w,
    input wire logic nak_dev,
    input wire logic [15:0] stretch_ns,
    output logic scl_pull,
    output logic sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];
    logic [7:0] latch = 8'h55;
    logic [7:0] sh = 8'h00;
    logic [15:0] devs = 16'h0000;
    logic [7:0] addr_seen = 8'hff;
    int bitn = 0;
    int stops = 0;
    bit active = 0;
    bit rd = 0;
    bit first = 0;
    bit ack_slot = 0;
    bit go = 0;
    initial begin
        scl_pull = 0;
        sda_pull = 0;
    end
    always @(negedge sda_w) if (scl_w === 1'b1) begin
        active = 1;
        first = 1;
        rd = 0;
        bitn = 0;
        ack_slot = 0;
    end
    always @(posedge sda_w) if (scl_w === 1'b1) begin
        active = 0;
        stops++;
    end
    always @(posedge scl_w) if (active) begin
        if (ack_slot) begin
            go = rd ? !sda_w : go;
        end else begin
            sh = {sh[6:0], sda_w};
            bitn++;
        end
    end
    always @(negedge scl_w) if (active) begin
        if (ack_slot) begin
            ack_slot = 0;
            bitn = 0;
            active = go;
            sda_pull = go && rd && !mem[latch][7];
        end else if (bitn == 8) begin
            ack_slot = 1;
            if (rd) begin
                latch++;
                sda_pull = 0;
            end else begin
                if (first) begin
                    devs = {devs[7:0], sh};
                    rd = sh[0];
                    go = (sh[7:1] == 7'h50) && !nak_dev;
                end else begin
                    latch = sh;
                    addr_seen = sh;
                    go = 1;
                end
                first = 0;
                sda_pull = go;
            end
        end else if (rd) begin
            sda_pull = !mem[latch][3'(7 - bitn)];
        end
    end
    always @(negedge scl_w) if (stretch_ns != 16'h0000) begin
        scl_pull = 1;
        #(stretch_ns);
        scl_pull = 0;
    end
endmodule

// ### testbench/tb_serial_eeprom_boot_loader.sv
// Self-checking bench for the boot loader with an EEPROM model and a stalling memory port.
`define chk(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_serial_eeprom_boot_loader;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0;
    logic reset = 1;
    logic [10:0] boot_word_count = 11'h004;
    logic mem_wr_ready = 0;
    logic nak_dev = 0;
    logic stall = 0;
    logic [15:0] stretch_ns = 16'h0000;
    logic [7:0] cnt = 8'h00;
    logic scl_out, scl_oe_n, sda_out, sda_oe_n, scl_pull, sda_pull;
    logic mem_wr_valid, base_copy_match, boot_busy, boot_done, boot_error;
    logic [31:0] mem_wr_addr, mem_wr_data, sdram_window_base;
    wire scl_w = (scl_oe_n | scl_out) & !scl_pull;
    wire sda_w = (sda_oe_n | sda_out) & !sda_pull;
    logic [63:0] words [$];
    logic held = 0;
    logic [63:0] held_v = 64'h0;
    int num_errors = 0;
    int n_tests = 0;

    always #5 clk_sys = ~clk_sys;

    serial_eeprom_boot_loader dut_u (.clk_sys(clk_sys), .reset(reset),
        .boot_word_count(boot_word_count), .scl_in(scl_w), .scl_out(scl_out),
        .scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data), .sdram_window_base(sdram_window_base),
        .base_copy_match(base_copy_match), .boot_busy(boot_busy), .boot_done(boot_done),
        .boot_error(boot_error));

    eeprom_model ee_u (.scl_w(scl_w), .sda_w(sda_w), .nak_dev(nak_dev),
        .stretch_ns(stretch_ns), .scl_pull(scl_pull), .sda_pull(sda_pull));

    // The memory side accepts every cycle, or once in eight when stalling.
    always @(posedge clk_sys) begin
        cnt <= cnt + 8'h01;
        mem_wr_ready <= stall ? (cnt[2:0] == 3'h0) : 1'b1;
        if (held) `chk({mem_wr_valid, mem_wr_addr, mem_wr_data}, {1'b1, held_v})
        if (mem_wr_valid === 1'b1 && mem_wr_ready) words.push_back({mem_wr_addr, mem_wr_data});
        held <= mem_wr_valid === 1'b1 && !mem_wr_ready && !reset;
        held_v <= {mem_wr_addr, mem_wr_data};
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic run_boot(input logic [10:0] n, input logic [31:0] base, input logic copy_ok,
                            input logic nak, input logic slow);
        logic [31:0] w;
        int k;
        for (int i = 0; i < 256; i++) ee_u.mem[i] = 8'(i * 7 + 49);
        for (int i = 0; i < 4; i++) begin
            ee_u.mem[23 + i] = base[31 - 8 * i -: 8];
            ee_u.mem[43 + i] = copy_ok ? base[31 - 8 * i -: 8] : ~base[31 - 8 * i -: 8];
        end
        ee_u.latch = 8'h55;
        ee_u.stops = 0;
        words.delete();
        @(posedge clk_sys);
        reset <= 1'b1;
        boot_word_count <= n;
        nak_dev <= nak;
        stall <= slow;
        stretch_ns <= slow ? 16'h012c : 16'h0000;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        k = 0;
        while (!(boot_done === 1'b1 || boot_error === 1'b1) && k < 60000) begin
            @(posedge clk_sys);
            k++;
        end
        repeat (4) @(posedge clk_sys);
        `chk({boot_done, boot_error, boot_busy}, {!nak, nak, 1'b0})
        `chk({scl_oe_n, sda_oe_n, ee_u.stops}, {2'b11, 32'h1})
        `chk(words.size(), nak ? 0 : int'(n))
        if (!nak) begin
            `chk({ee_u.devs, ee_u.addr_seen}, 24'ha0a100)
            `chk(sdram_window_base, base)
            `chk(base_copy_match, copy_ok)
            for (int j = 0; j < int'(n); j++) begin
                w = {ee_u.mem[47 + 4 * j], ee_u.mem[48 + 4 * j],
                     ee_u.mem[49 + 4 * j], ee_u.mem[50 + 4 * j]};
                `chk(words[j], {base + 32'(4 * j), w})
            end
        end
    endtask

    // Four words with a prompt EEPROM and memory side.
    task automatic t_fast();
        run_boot(11'h004, 32'h1000_0040, 1'b1, 1'b0, 1'b0);
        $display("test fast finished");
    endtask

    // Empty image: header only, no word written.
    task automatic t_zero();
        run_boot(11'h000, 32'h0000_0100, 1'b1, 1'b0, 1'b0);
        $display("test zero finished");
    endtask

    // Clock stretching, memory stalls and a differing second base copy.
    task automatic t_slow();
        run_boot(11'h006, 32'hfedc_ba98, 1'b0, 1'b0, 1'b1);
        $display("test slow finished");
    endtask

    // The EEPROM refuses its device byte.
    task automatic t_nak();
        run_boot(11'h004, 32'h2000_0000, 1'b1, 1'b1, 1'b0);
        $display("test refused finished");
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        t_fast();
        t_zero();
        t_slow();
        t_nak();
        print_verdict();
    end

    initial begin
        repeat (90000) @(posedge clk_sys);
        num_errors++;
        print_verdict();
    end
endmodule
